// *** design/input_signal_allocation_mux.sv ***
// Sequence input allocation mux with AXI4-Lite configuration registers
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "input_alloc_defines.svh"
// Functional notes
// R01: Selector codes honoured only when mode equals 1
// R02: Codes 0-6 and 9-F route pins, opposite levels
// R03: Code 7 always asserted, 8 always deasserted
// R04: Shared pin drives all selecting inputs
// R05: Overtravel codes 0-6 high-active, 9-F low-active
// R06: Direction switch input routable like others
// R07: Integrators keep safety input polarity at factory
// R08: Saved setting applies only after power cycle; code applies it on rst, and por restores factory settings
// R09: Sink inputs asserted low; source reversed
// R10: Mode not 1 uses factory routing
module input_signal_allocation_mux (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic por,
	input wire logic [6:0] seq_pin,
	output logic servo_on,
	output logic proportional_op_input,
	output logic forward_overtravel_input,
	output logic reverse_overtravel_input,
	output logic alarm_reset,
	output logic fwd_torque_limit_input,
	output logic rev_torque_limit_input,
	output logic direction_switch_input,
	output logic speed_select_a_input,
	output logic speed_select_b_input,
	output logic control_method_select,
	output logic zero_hold_input,
	output logic pulse_inhibit,
	output logic gain_changeover,
	output logic pulse_mult_select,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ------------------------------------------------------------
	// Saved and active configuration
	// ------------------------------------------------------------
	input_alloc_pkg::sel_code_t saved_code [`IA_NUM_SIG];
	input_alloc_pkg::sel_code_t next_saved_code [`IA_NUM_SIG];
	input_alloc_pkg::sel_code_t active_code [`IA_NUM_SIG];
	logic [3:0] saved_mode;
	logic [3:0] next_saved_mode;
	logic saved_source;
	logic next_saved_source;
	logic [3:0] active_mode;
	logic active_source;

	// AXI write side
	logic aw_held;
	logic next_aw_held;
	logic [`IA_ADDR_W-1:0] aw_addr;
	logic [`IA_ADDR_W-1:0] next_aw_addr;
	logic w_held;
	logic next_w_held;
	logic [31:0] w_data;
	logic [31:0] next_w_data;
	logic [3:0] w_strb;
	logic [3:0] next_w_strb;
	logic bvalid;
	logic next_bvalid;
	logic [1:0] bresp;
	logic [1:0] next_bresp;
	logic do_write;

	// AXI read side
	logic rvalid;
	logic next_rvalid;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic [1:0] rresp;
	logic [1:0] next_rresp;

	input_alloc_pkg::logical_vec_t routed;
	input_alloc_pkg::logical_vec_t logical;

	assign s_axi_awready = !aw_held && !bvalid;
	assign s_axi_wready = !w_held && !bvalid;
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_arready = !rvalid;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rdata = rdata;
	assign s_axi_rresp = rresp;
	assign do_write = aw_held && w_held && !bvalid;

	// ------------------------------------------------------------
	// Write channel and saved settings
	// ------------------------------------------------------------
	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_saved_mode = saved_mode;
		next_saved_source = saved_source;
		next_saved_code = saved_code;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr[`IA_ADDR_W-1:0];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = `IA_RESP_OKAY;
			case (aw_addr)
				`IA_OFS_CONFIG: begin
					if (w_strb[0]) begin
						next_saved_mode = w_data[`IA_CFG_MODE_MSB:`IA_CFG_MODE_LSB];
						next_saved_source = w_data[`IA_CFG_SOURCE_BIT];
					end
				end
				`IA_OFS_SEL_LO: begin
					for (int i = 0; i < 8; i++) begin
						if (w_strb[i/2]) begin
							next_saved_code[i] = w_data[i*4 +: 4];
						end
					end
				end
				`IA_OFS_SEL_HI: begin
					for (int i = 8; i < `IA_NUM_SIG; i++) begin
						if (w_strb[(i-8)/2]) begin
							next_saved_code[i] = w_data[(i-8)*4 +: 4];
						end
					end
				end
				`IA_OFS_STATUS, `IA_OFS_ACTIVE: next_bresp = `IA_RESP_OKAY;
				default: begin
					next_bresp = `IA_RESP_SLVERR;
				end
			endcase
		end
	end

	// R08 saved survives rst
	// Only power-on clears saved settings; rst stands in for the power cycle
	always_ff @(posedge core_clk) begin
		if (por) begin
			saved_mode <= `IA_MODE_RESET;
			saved_source <= `IA_SOURCE_RESET;
			for (int i = 0; i < `IA_NUM_SIG; i++) begin
				saved_code[i] <= sel_code_t_factory(i);
			end
		end else begin
			saved_mode <= next_saved_mode;
			saved_source <= next_saved_source;
			saved_code <= next_saved_code;
		end
	end

	function automatic input_alloc_pkg::sel_code_t sel_code_t_factory(input int idx);
		logic [59:0] codes;
		codes = `IA_FACTORY_CODES;
		return codes[idx*4 +: 4];
	endfunction : sel_code_t_factory

	always_ff @(posedge core_clk) begin
		if (rst) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= `IA_RESP_OKAY;
		end else begin
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held <= next_w_held;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
		end
	end

	// ------------------------------------------------------------
	// Active configuration
	// ------------------------------------------------------------
	// R08 load on restart
	// Saved settings are copied only while rst is held, never live
	always_ff @(posedge core_clk) begin
		if (por) begin
			active_mode <= `IA_MODE_RESET;
			active_source <= `IA_SOURCE_RESET;
			for (int i = 0; i < `IA_NUM_SIG; i++) begin
				active_code[i] <= sel_code_t_factory(i);
			end
		end else if (rst) begin
			active_mode <= saved_mode;
			active_source <= saved_source;
			active_code <= saved_code;
		end
	end

	// ------------------------------------------------------------
	// Per-signal routing
	// ------------------------------------------------------------
	generate
		for (genvar g = 0; g < `IA_NUM_SIG; g++) begin : g_route
			input_alloc_pkg::sel_code_t code;
			logic [2:0] pin_idx;
			logic pin_on;
			logic opposite;
			logic high_active;
			// R01 R10 mode gate
			assign code = (active_mode == `IA_MODE_USER) ? active_code[g] :
				sel_code_t_factory(g);
			assign opposite = (code >= `IA_CODE_FIRST_INV);
			// R02 pin select
			assign pin_idx = opposite ? 3'(code - `IA_CODE_FIRST_INV) : code[2:0];
			// R09 sink low is on
			assign pin_on = (pin_idx < 3'h7) ? (!seq_pin[pin_idx] ^ active_source) : 1'b0;
			// R05 R06 polarity per signal
			assign high_active = logic'((`IA_HIGH_ACTIVE_MASK >> g) & 15'h0001);
			// R03 R04 constant or shared pin
			assign routed[g] = (code == `IA_CODE_ALWAYS_ON) ||
				((code != `IA_CODE_ALWAYS_OFF) && (pin_on ^ opposite ^ high_active));
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (rst) begin
			logical <= 15'h0000;
		end else begin
			logical <= routed;
		end
	end

	assign servo_on = logical[0];
	assign proportional_op_input = logical[1];
	assign forward_overtravel_input = logical[2];
	assign reverse_overtravel_input = logical[3];
	assign alarm_reset = logical[4];
	assign fwd_torque_limit_input = logical[5];
	assign rev_torque_limit_input = logical[6];
	assign direction_switch_input = logical[7];
	assign speed_select_a_input = logical[8];
	assign speed_select_b_input = logical[9];
	assign control_method_select = logical[10];
	assign zero_hold_input = logical[11];
	assign pulse_inhibit = logical[12];
	assign gain_changeover = logical[13];
	assign pulse_mult_select = logical[14];

	// ------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------
	always_comb begin
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && !rvalid) begin
			next_rvalid = 1'b1;
			next_rresp = `IA_RESP_OKAY;
			next_rdata = 32'h00000000;
			case (s_axi_araddr[`IA_ADDR_W-1:0])
				`IA_OFS_CONFIG: begin
					next_rdata[`IA_CFG_MODE_MSB:`IA_CFG_MODE_LSB] = saved_mode;
					next_rdata[`IA_CFG_SOURCE_BIT] = saved_source;
				end
				`IA_OFS_SEL_LO: begin
					for (int i = 0; i < 8; i++) begin
						next_rdata[i*4 +: 4] = saved_code[i];
					end
				end
				`IA_OFS_SEL_HI: begin
					for (int i = 8; i < `IA_NUM_SIG; i++) begin
						next_rdata[(i-8)*4 +: 4] = saved_code[i];
					end
				end
				`IA_OFS_STATUS: begin
					next_rdata[`IA_STAT_PIN_LSB +: `IA_NUM_PIN] = seq_pin;
					next_rdata[`IA_STAT_LOG_LSB +: `IA_NUM_SIG] = logical;
				end
				`IA_OFS_ACTIVE: begin
					next_rdata[`IA_CFG_MODE_MSB:`IA_CFG_MODE_LSB] = active_mode;
					next_rdata[`IA_CFG_SOURCE_BIT] = active_source;
				end
				default: begin
					next_rresp = `IA_RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `IA_RESP_OKAY;
		end else begin
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

endmodule : input_signal_allocation_mux
`default_nettype wire

// *** design/input_alloc_defines.svh ***
// Offsets, field positions, reset values and selector codes of the input allocation block
`ifndef INPUT_ALLOC_DEFINES_SVH
`define INPUT_ALLOC_DEFINES_SVH

`define IA_NUM_SIG 15
`define IA_NUM_PIN 7
`define IA_ADDR_W 5

`define IA_OFS_CONFIG 5'h00
`define IA_OFS_SEL_LO 5'h04
`define IA_OFS_SEL_HI 5'h08
`define IA_OFS_STATUS 5'h0C
`define IA_OFS_ACTIVE 5'h10

`define IA_CFG_MODE_LSB 0
`define IA_CFG_MODE_MSB 3
`define IA_CFG_SOURCE_BIT 4
`define IA_STAT_PIN_LSB 0
`define IA_STAT_LOG_LSB 16

`define IA_MODE_USER 4'h1
`define IA_MODE_RESET 4'h0
`define IA_SOURCE_RESET 1'b0
`define IA_FACTORY_CODES 60'h888888886543210
`define IA_HIGH_ACTIVE_MASK 15'h000C

`define IA_CODE_LAST_DIRECT 4'h6
`define IA_CODE_ALWAYS_ON 4'h7
`define IA_CODE_ALWAYS_OFF 4'h8
`define IA_CODE_FIRST_INV 4'h9

`define IA_RESP_OKAY 2'h0
`define IA_RESP_SLVERR 2'h2

`endif

// *** design/input_alloc_pkg.sv ***
// Types of the input allocation block
package input_alloc_pkg;
	typedef logic [3:0] sel_code_t;
	typedef logic [14:0] logical_vec_t;
	typedef logic [6:0] pin_vec_t;
endpackage : input_alloc_pkg

// *** tb/contact_bank.sv ***
// External contact bank that drives the sequence input pins
`timescale 1ns/1ns
`default_nettype none
module contact_bank (
	input wire logic core_clk,
	input wire logic [6:0] contact_state,
	output logic [6:0] seq_pin
);
	// contacts keep one sense; configuration picks polarity
	// Contacts move one cycle after a command, never mid-cycle
	always_ff @(posedge core_clk) begin
		seq_pin <= contact_state;
	end
endmodule : contact_bank
`default_nettype wire

// *** tb/alloc_checker_assertions.sv ***
// Bus handshake, reset and factory routing checks of the input allocation mux
`timescale 1ns/1ns
`default_nettype none
module alloc_checker (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic por,
	input wire logic [6:0] seq_pin,
	input wire logic servo_on,
	input wire logic reverse_overtravel_input,
	input wire logic pulse_mult_select,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp
);
	// Factory routing holds from power-on until a write meets a reset
	logic pend;
	logic fact;
	always_ff @(posedge core_clk) begin
		pend <= !rst && (pend || (s_axi_awvalid && s_axi_awready));
		fact <= por || (fact && !(rst && pend));
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	chk_wr_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write unanswered");
	chk_rd_answer: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read unanswered");
	chk_rd_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data not released");
	chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while busy");
	chk_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while busy");
	chk_unmapped_rd: assert property (rd_taken ##0 (s_axi_araddr[4:2] > 3'h4)
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read");
	chk_reset_clear: assert property ($fell(rst) |-> !servo_on && !reverse_overtravel_input)
		else $error("output set after reset");
	chk_factory_map: assert property (fact && !$past(rst)
		|-> servo_on == !$past(seq_pin[0]) && !pulse_mult_select
		&& reverse_overtravel_input == $past(seq_pin[3])) else $error("factory routing wrong");
endmodule : alloc_checker
bind input_signal_allocation_mux alloc_checker u_chk (.*);
`default_nettype wire

// *** tb/input_signal_allocation_mux_tb.sv ***
// Self-checking bench of the input allocation mux
`timescale 1ns/1ns
`default_nettype none
module input_signal_allocation_mux_tb;
	logic core_clk = 1'b0, rst = 1'b1, por = 1'b1;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [6:0] contact_state = 7'h0, seq_pin;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic servo_on, proportional_op_input, forward_overtravel_input, reverse_overtravel_input;
	logic alarm_reset, fwd_torque_limit_input, rev_torque_limit_input, direction_switch_input;
	logic speed_select_a_input, speed_select_b_input, control_method_select, zero_hold_input;
	logic pulse_inhibit, gain_changeover, pulse_mult_select;
	int failures = 0, tests_run = 0;
	wire logic [14:0] obs = {pulse_mult_select, gain_changeover, pulse_inhibit, zero_hold_input,
		control_method_select, speed_select_b_input, speed_select_a_input, direction_switch_input,
		rev_torque_limit_input, fwd_torque_limit_input, alarm_reset, reverse_overtravel_input,
		forward_overtravel_input, proportional_op_input, servo_on};
	input_signal_allocation_mux u_dut (.*);
	contact_bank u_contacts (.*);
	initial forever #2 core_clk = ~core_clk;
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		tests_run++;
		if (seen !== want) begin
			failures++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, want);
		end
	endtask : chk
	function automatic logic [14:0] expect_out(input logic [59:0] c, input logic [6:0] p,
		input logic s, input logic u);
		logic [3:0] k;
		logic [3:0] x;
		for (int i = 0; i < 15; i++) begin
			k = u ? c[4*i+:4] : (i < 7 ? 4'(i) : 4'h8);
			x = k > 4'h8 ? k - 4'h9 : k;
			expect_out[i] = k == 4'h7 || (k != 4'h8
				&& (p[x[2:0]] ^ !s ^ (k > 4'h8) ^ (i == 2 || i == 3)));
		end
	endfunction : expect_out
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic [1:0] r);
		int n;
		@(posedge core_clk);
		s_axi_awaddr <= {27'h0, a};
		s_axi_araddr <= {27'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		for (n = 0; n < 40; n++) begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			q = s_axi_rdata;
			r = w ? s_axi_bresp : s_axi_rresp;
			if (w ? s_axi_bvalid : s_axi_rvalid) break;
		end
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		if (n == 40) begin
			failures++;
			tally_and_finish();
		end
	endtask : bus
	task automatic pins_check(input logic [59:0] c, input logic [3:0] m, input logic s);
		logic [6:0] v;
		logic [31:0] q;
		logic [1:0] r;
		v = 7'($urandom);
		@(posedge core_clk);
		contact_state <= v;
		repeat (3) @(posedge core_clk);
		chk(32'(obs), 32'(expect_out(c, v, s, m == 4'h1)));
		bus(1'b0, 5'h0C, 32'h0, q, r);
		chk(q, {1'b0, expect_out(c, v, s, m == 4'h1), 9'h0, v});
	endtask : pins_check
	initial begin
		logic [31:0] q;
		logic [1:0] r;
		logic [59:0] c, pc;
		logic [3:0] m, pm;
		logic s, ps;
		void'($urandom(74));
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		por <= 1'b0;
		pc = 60'h0;
		pm = 4'h0;
		ps = 1'b0;
		bus(1'b1, 5'h0C, 32'hFFFFFFFF, q, r);
		chk(32'(r), 32'h0);
		for (int i = 0; i < 6; i++) begin
			if (i == 3) continue;
			bus(1'b0, 5'(4 * i), 32'h0, q, r);
			chk(q, i == 1 ? 32'h86543210 : i == 2 ? 32'h08888888 : 32'h0);
			chk(32'(r), i == 5 ? 32'h2 : 32'h0);
		end
		bus(1'b1, 5'h1C, 32'hFFFFFFFF, q, r);
		chk(32'(r), 32'h2);
		$display("test reset values done");
		for (int t = 0; t < 8; t++) begin
			m = t == 1 ? 4'h2 : t == 5 ? 4'($urandom) : 4'h1;
			s = t > 3;
			c = t == 0 ? 60'hFEDCBA987654321 : t == 2 ? 60'h0 : 60'({$urandom, $urandom});
			bus(1'b1, 5'h00, {27'h0, s, m}, q, r);
			bus(1'b1, 5'h04, c[31:0], q, r);
			bus(1'b1, 5'h08, {4'h0, c[59:32]}, q, r);
			bus(1'b0, 5'h08, 32'h0, q, r);
			chk(q, {4'h0, c[59:32]});
			pins_check(pc, pm, ps);
			@(posedge core_clk);
			rst <= 1'b1;
			repeat (2) @(posedge core_clk);
			chk(32'(obs), 32'h0);
			rst <= 1'b0;
			repeat (4) pins_check(c, m, s);
			pc = c;
			pm = m;
			ps = s;
			$display("test routing %0d done", t);
		end
		tally_and_finish();
	end
endmodule : input_signal_allocation_mux_tb
`default_nettype wire
